// >>> verilog/cap_sense_defines.svh
// Register offsets, bit positions, reset values and timing figures of the counter unit.
`ifndef CAP_SENSE_DEFINES_SVH
`define CAP_SENSE_DEFINES_SVH

`define CS_ADDR_CTRL_PRIMARY    8'ha0
`define CS_ADDR_CTRL_SECONDARY  8'ha1
`define CS_ADDR_COUNT_LOW       8'ha4
`define CS_ADDR_COUNT_HIGH      8'ha5

`define CS_CTRL_PRIMARY_RESET   8'h00
`define CS_CTRL_SECONDARY_RESET 8'h00
`define CS_CTRL_PRIMARY_MASK    8'hff
`define CS_CTRL_SECONDARY_MASK  8'hff

`define CS_P_ENABLE             0
`define CS_P_MODE_LSB           1
`define CS_P_SIGMA_DELTA        3
`define CS_P_COUNTER_CLK_SRC    4
`define CS_P_SWITCH_CLK_SEL     5
`define CS_P_OUT_SEL_LSB        6

`define CS_S_EVENT_SEL_LSB      0
`define CS_S_INPUT_INVERT       3
`define CS_S_ALT_HIGH_CLK       4
`define CS_S_CLK_DIV_LSB        5
`define CS_S_CHAIN              7

`define CS_EVENT_SEL_ZERO       3'h7
`define CS_SYNC_LOW_RATE_OSC    7
`define CS_SYNC_PRS             8
`define CS_SYNC_TIMER_START     9
`define CS_SYNC_WIDTH           10

`define CS_PRESCALE_DIV         8'h04
`define CS_COUNT_MAX            8'hff

`endif

// >>> verilog/cap_sense_pkg.sv
// Types shared by the counter control unit and its rate divider.
package cap_sense_pkg;

    typedef enum logic [1:0] {
        MODE_STOP_ON_EVENT = 2'b00,
        MODE_PULSE_WIDTH   = 2'b01,
        MODE_PERIOD        = 2'b10,
        MODE_CONTINUOUS    = 2'b11
    } count_mode_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_RUN  = 2'b10,
        ST_HOLD = 2'b11
    } count_state_e;

    typedef enum logic [1:0] {
        OUT_EVENT_INPUT = 2'b00,
        OUT_UNIT_IRQ    = 2'b01,
        OUT_LOW_CARRY   = 2'b10,
        OUT_HIGH_CARRY  = 2'b11
    } out_sel_e;

    typedef struct packed {
        logic [2:0] cnt;
        logic       tick;
    } div_state_s;

    typedef struct packed {
        logic [7:0]   ctrl_primary;
        logic [7:0]   ctrl_secondary;
        logic [7:0]   rdata;
        logic [9:0]   sync1;
        logic [9:0]   sync2;
        logic         data_prev;
        logic         lro_prev;
        count_state_e st;
        logic [7:0]   cnt_lo;
        logic [7:0]   cnt_hi;
        logic         carry_lo;
        logic         carry_hi;
        logic         out_pin;
        logic         sw_clk;
        logic [7:0]   pre_cnt;
        logic         pre_tick;
        logic         pre_free;
    } unit_state_s;

endpackage

// >>> verilog/clk_rate_divider.sv
// Divides a tick stream by one, two, four or eight into one-cycle enable pulses.
`include "cap_sense_defines.svh"

module clk_rate_divider
(
    // Clock and reset.
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    // Source rate and divide choice.
    input  wire logic       src_tick_i,
    input  wire logic [1:0] div_sel_i,
    // Divided rate.
    output logic            tick_o
);
    import cap_sense_pkg::*;

    div_state_s q;
    div_state_s d;
    logic [2:0] mask;

    always_comb begin
        d = q;
        d.tick = 1'b0;
        unique case (div_sel_i)
            2'b00: mask = 3'h0;
            2'b01: mask = 3'h1;
            2'b10: mask = 3'h3;
            2'b11: mask = 3'h7;
        endcase
        // The divider resets only on arst_n_i, not when enable clears the unit, so its phase is arbitrary.
        if (src_tick_i) begin
            d.cnt = q.cnt + 3'h1;
            d.tick = ((q.cnt & mask) == mask);
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick_o = q.tick;

endmodule

// >>> verilog/cap_sense_counter_control.sv
// Control, mode logic and chained counters of the capacitive-sensing counter unit.
// Notes on behaviour
// - Output select routes event input, unit interrupt, low carry or high carry.
// - Switch clock is the prescaled clock at zero, the sequence generator at one.
// - Counter clock dividers take the main clock at zero, prescaled clock at one.
// - Sigma-delta bit gates counting and moves the timer onto the prescaled clock.
// - Once sigma-delta mode is set the prescaler runs free and never stops.
// - Stop-on-event counts from enable and halts at the unit interrupt event.
// - Pulse width waits for a rising data edge and stops at the falling edge.
// - Period counts from one rising data edge to the next rising edge.
// - Continuous mode wraps every 100h counts, or 10000h counts when chained.
// - Enable one starts counting; enable zero stops and clears both counters.
// - A halted count stays readable until enable is written to zero.
// - Chain zero runs two independent byte counters; chain one makes sixteen bits.
// - Divide field gives the selected counter clock divided by one, two, four or eight.
// - Alternate bit clocks the high counter from the low-rate oscillator while chain is zero.
// - Invert bit flips the selected data input when set.
// - Input select picks one of seven event sources or constant zero.
// - Sigma-delta counting advances only while comparator and timer start are high.
//
// Added by the designer: the address-and-strobe port.
`include "cap_sense_defines.svh"

module cap_sense_counter_control
(
    // Clock and reset.
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    // Register port.
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic [7:0]      rdata_o,
    // Asynchronous sources: bit 0 comparator zero up to bit 6 analog bus.
    input  wire logic [6:0] event_src_i,
    input  wire logic       low_rate_osc_i,
    input  wire logic       prs_i,
    input  wire logic       timer_start_i,
    // Unit interrupt from the status logic on this clock.
    input  wire logic       unit_irq_i,
    // Outputs.
    output logic            out_pin_o,
    output logic            switch_clk_o,
    output logic            timer_on_prescaled_o,
    output logic            low_carry_o,
    output logic            high_carry_o
);
    import cap_sense_pkg::*;

    unit_state_s q;
    unit_state_s d;
    logic        count_tick;
    logic        div_src;
    logic        en;
    logic        en_next;
    logic        sd;
    logic        sel_in;
    logic        data;
    logic        rise;
    logic        fall;
    logic        gate;
    logic        inc_lo;
    logic        inc_hi;
    logic        lo_wrap;
    logic        hi_wrap;
    logic        lro_rise;
    logic        pre_run;
    count_mode_e mode;
    logic [2:0]  ev_sel;

    // Counter clock source feeds the divide-by-1/2/4/8 stage.
    assign div_src = q.ctrl_primary[`CS_P_COUNTER_CLK_SRC] ? q.pre_tick : 1'b1;

    clk_rate_divider u_div (
        .clk_i      (clk_i),
        .arst_n_i   (arst_n_i),
        .src_tick_i (div_src),
        .div_sel_i  (q.ctrl_secondary[`CS_S_CLK_DIV_LSB +: 2]),
        .tick_o     (count_tick)
    );

    always_comb begin
        d = q;
        en = q.ctrl_primary[`CS_P_ENABLE];
        sd = q.ctrl_primary[`CS_P_SIGMA_DELTA];
        mode = count_mode_e'(q.ctrl_primary[`CS_P_MODE_LSB +: 2]);
        ev_sel = q.ctrl_secondary[`CS_S_EVENT_SEL_LSB +: 3];

        d.sync1 = {timer_start_i, prs_i, low_rate_osc_i, event_src_i};
        d.sync2 = q.sync1;

        if (ev_sel == `CS_EVENT_SEL_ZERO) begin
            sel_in = 1'b0;
        end else begin
            sel_in = q.sync2[ev_sel];
        end
        data = sel_in ^ q.ctrl_secondary[`CS_S_INPUT_INVERT];
        rise = data & ~q.data_prev;
        fall = ~data & q.data_prev;
        d.data_prev = data;
        lro_rise = q.sync2[`CS_SYNC_LOW_RATE_OSC] & ~q.lro_prev;
        d.lro_prev = q.sync2[`CS_SYNC_LOW_RATE_OSC];

        // Prescaler: once sigma-delta mode is seen it is never halted again.
        d.pre_free = q.pre_free | sd;
        pre_run = q.pre_free | sd | en;
        d.pre_tick = 1'b0;
        if (pre_run) begin
            if (q.pre_cnt == `CS_PRESCALE_DIV - 8'h01) begin
                d.pre_cnt = 8'h00;
                d.pre_tick = 1'b1;
            end else begin
                d.pre_cnt = q.pre_cnt + 8'h01;
            end
        end else begin
            d.pre_cnt = 8'h00;
        end

        unique case (q.st)
            ST_IDLE: begin
                if (en) begin
                    if (mode == MODE_PULSE_WIDTH || mode == MODE_PERIOD) begin
                        d.st = ST_WAIT;
                    end else begin
                        d.st = ST_RUN;
                    end
                end
            end
            ST_WAIT: begin
                if (rise) begin
                    d.st = ST_RUN;
                end
            end
            ST_RUN: begin
                if (mode == MODE_STOP_ON_EVENT && unit_irq_i) begin
                    d.st = ST_HOLD;
                end else if (mode == MODE_PULSE_WIDTH && fall) begin
                    d.st = ST_HOLD;
                end else if (mode == MODE_PERIOD && rise) begin
                    d.st = ST_HOLD;
                end
            end
            ST_HOLD: begin
                d.st = ST_HOLD;
            end
        endcase

        // Counting gate; the synchronised comparator and timer start hold it in sigma-delta.
        gate = ~sd | (q.sync2[0] & q.sync2[`CS_SYNC_TIMER_START]);
        inc_lo = (q.st == ST_RUN) && count_tick && gate;
        lo_wrap = inc_lo && (q.cnt_lo == `CS_COUNT_MAX);
        if (q.ctrl_secondary[`CS_S_CHAIN]) begin
            inc_hi = lo_wrap;
        end else if (q.ctrl_secondary[`CS_S_ALT_HIGH_CLK]) begin
            inc_hi = (q.st == ST_RUN) && lro_rise && gate;
        end else begin
            inc_hi = inc_lo;
        end
        hi_wrap = inc_hi && (q.cnt_hi == `CS_COUNT_MAX);
        if (inc_lo) begin
            d.cnt_lo = q.cnt_lo + 8'h01;
        end
        if (inc_hi) begin
            d.cnt_hi = q.cnt_hi + 8'h01;
        end
        d.carry_lo = lo_wrap;
        d.carry_hi = hi_wrap;

        // The write masks are all ones, so every bit position stores what is written.
        if (wr_i && addr_i == `CS_ADDR_CTRL_PRIMARY) begin
            d.ctrl_primary = wdata_i & `CS_CTRL_PRIMARY_MASK;
        end
        if (wr_i && addr_i == `CS_ADDR_CTRL_SECONDARY) begin
            d.ctrl_secondary = wdata_i & `CS_CTRL_SECONDARY_MASK;
        end

        // Clearing on the write itself keeps a stale count from surviving one cycle.
        en_next = d.ctrl_primary[`CS_P_ENABLE];
        if (!en_next) begin
            d.st = ST_IDLE;
            d.cnt_lo = 8'h00;
            d.cnt_hi = 8'h00;
            d.carry_lo = 1'b0;
            d.carry_hi = 1'b0;
        end

        d.rdata = 8'h00;
        if (rd_i) begin
            unique case (addr_i)
                `CS_ADDR_CTRL_PRIMARY:   d.rdata = q.ctrl_primary;
                `CS_ADDR_CTRL_SECONDARY: d.rdata = q.ctrl_secondary;
                `CS_ADDR_COUNT_LOW:      d.rdata = q.cnt_lo;
                `CS_ADDR_COUNT_HIGH:     d.rdata = q.cnt_hi;
                default:                 d.rdata = 8'h00;
            endcase
        end

        unique case (out_sel_e'(q.ctrl_primary[`CS_P_OUT_SEL_LSB +: 2]))
            OUT_EVENT_INPUT: d.out_pin = data;
            OUT_UNIT_IRQ:    d.out_pin = unit_irq_i;
            OUT_LOW_CARRY:   d.out_pin = q.carry_lo;
            OUT_HIGH_CARRY:  d.out_pin = q.carry_hi;
        endcase

        if (q.ctrl_primary[`CS_P_SWITCH_CLK_SEL]) begin
            d.sw_clk = q.sync2[`CS_SYNC_PRS];
        end else begin
            d.sw_clk = q.pre_tick;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q <= '0;
            q.ctrl_primary <= `CS_CTRL_PRIMARY_RESET;
            q.ctrl_secondary <= `CS_CTRL_SECONDARY_RESET;
        end else begin
            q <= d;
        end
    end

    assign rdata_o = q.rdata;
    assign out_pin_o = q.out_pin;
    assign switch_clk_o = q.sw_clk;
    assign timer_on_prescaled_o = q.ctrl_primary[`CS_P_SIGMA_DELTA];
    assign low_carry_o = q.carry_lo;
    assign high_carry_o = q.carry_hi;

    a_disable_clears: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !q.ctrl_primary[0] |-> (q.cnt_lo == 8'h00 && q.cnt_hi == 8'h00 && q.st == ST_IDLE))
        else $error("counters not cleared while disabled");

    a_hold_stable: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (q.st == ST_HOLD && q.ctrl_primary[0]) ##1 q.ctrl_primary[0] |->
        ($stable(q.cnt_lo) && $stable(q.cnt_hi)))
        else $error("held count changed");

    a_stop_event: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (q.st == ST_RUN && q.ctrl_primary[2:1] == 2'b00 && unit_irq_i && !wr_i) |=>
        q.st == ST_HOLD)
        else $error("stop on event did not halt");

    a_width_stop: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (q.st == ST_RUN && q.ctrl_primary[2:1] == 2'b01 && fall && !wr_i) |=>
        q.st == ST_HOLD)
        else $error("pulse width did not stop at falling edge");

    a_wait_start: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (q.st == ST_WAIT && !rise && !wr_i) |=> (q.st == ST_WAIT && q.cnt_lo == 8'h00))
        else $error("counting began without a rising edge");

    a_low_wrap: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (inc_lo && q.cnt_lo == 8'hff && !wr_i) |=> (q.cnt_lo == 8'h00 && q.carry_lo))
        else $error("low counter did not wrap at 100h");

    a_chain_step: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (q.ctrl_secondary[7] && inc_lo && q.cnt_lo == 8'hff && q.cnt_hi != 8'hff && !wr_i)
        |=> q.cnt_hi == $past(q.cnt_hi) + 8'h01)
        else $error("chained high byte did not step on low carry");

    a_sd_gate: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (q.ctrl_primary[3] && !(q.sync2[0] && q.sync2[9]) && !wr_i) |=> $stable(q.cnt_lo))
        else $error("sigma-delta counted without comparator and start");

    a_free_run: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        q.pre_free |=> (q.pre_free ##[0:4] q.pre_tick))
        else $error("prescaler stopped after sigma-delta mode");

    a_switch_clock: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ##1 switch_clk_o == ($past(q.ctrl_primary[5]) ? $past(q.sync2[8]) : $past(q.pre_tick)))
        else $error("switch clock source wrong");

    a_out_route: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (q.ctrl_primary[7:6] == 2'b01) |=> out_pin_o == $past(unit_irq_i))
        else $error("output select did not route the unit interrupt");

    a_zero_input: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (q.ctrl_secondary[2:0] == 3'h7) |-> data == q.ctrl_secondary[3])
        else $error("constant zero input not selected");

    // These guard the routing, mode entry and register paths that the bench touches in only a few directed cases.
    // Those on mode and counter paths exclude a write in the same cycle, since a write may legally end the count.
    a_out_low_carry: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (q.ctrl_primary[7:6] == 2'b10) |=> out_pin_o == $past(q.carry_lo))
        else $error("output select did not route the low carry");

    a_out_high_carry: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (q.ctrl_primary[7:6] == 2'b11) |=> out_pin_o == $past(q.carry_hi))
        else $error("output select did not route the high carry");

    a_out_event: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (q.ctrl_primary[7:6] == 2'b00) |=> out_pin_o == $past(data))
        else $error("output select did not route the event input");

    a_period_stop: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (q.st == ST_RUN && q.ctrl_primary[2:1] == 2'b10 && rise && !wr_i) |=>
        q.st == ST_HOLD)
        else $error("period did not stop at the next rising edge");

    a_edge_wait: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (q.st == ST_IDLE && q.ctrl_primary[0] && q.ctrl_primary[2] != q.ctrl_primary[1]
        && !wr_i) |=> q.st == ST_WAIT)
        else $error("edge mode did not wait for a rising edge");

    a_run_start: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (q.st == ST_IDLE && q.ctrl_primary[0] && q.ctrl_primary[2] == q.ctrl_primary[1]
        && !wr_i) |=> q.st == ST_RUN)
        else $error("counting did not start on enable");

    a_high_alt: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (!q.ctrl_secondary[7] && q.ctrl_secondary[4] && q.st == ST_RUN && lro_rise && gate
        && !wr_i) |=> q.cnt_hi == $past(q.cnt_hi) + 8'h01)
        else $error("high counter missed a low-rate clock edge");

    a_independent: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (!q.ctrl_secondary[7] && !q.ctrl_secondary[4] && inc_lo && !wr_i) |=>
        q.cnt_hi == $past(q.cnt_hi) + 8'h01)
        else $error("independent high counter did not step");

    a_high_wrap: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (inc_hi && q.cnt_hi == 8'hff && !wr_i) |=> (q.cnt_hi == 8'h00 && q.carry_hi))
        else $error("high counter did not wrap");

    a_reg_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (wr_i && addr_i == `CS_ADDR_CTRL_PRIMARY) |=> q.ctrl_primary == $past(wdata_i))
        else $error("primary control write not stored");

    a_read_data: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (rd_i && addr_i == `CS_ADDR_COUNT_LOW) |=> rdata_o == $past(q.cnt_lo))
        else $error("low count read returned a wrong value");

endmodule

// >>> testbench/tb_top.sv
// Self-checking bench for the capacitive-sensing counter control unit.
`include "cap_sense_defines.svh"
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin error_cnt++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import cap_sense_pkg::*;

    localparam logic [7:0] AP = `CS_ADDR_CTRL_PRIMARY;
    localparam logic [7:0] AS = `CS_ADDR_CTRL_SECONDARY;
    localparam logic [7:0] AL = `CS_ADDR_COUNT_LOW;
    localparam logic [7:0] AH = `CS_ADDR_COUNT_HIGH;

    logic       clk_i, arst_n_i, wr_i, rd_i;
    logic [7:0] addr_i, wdata_i, rdata_o;
    logic [6:0] event_src_i;
    logic       low_rate_osc_i, prs_i, timer_start_i, unit_irq_i;
    logic       out_pin_o, switch_clk_o, timer_on_prescaled_o, low_carry_o, high_carry_o;
    logic [7:0] v, h;
    int         error_cnt, n_tests, t, k;

    cap_sense_counter_control uut (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .event_src_i(event_src_i),
        .low_rate_osc_i(low_rate_osc_i), .prs_i(prs_i), .timer_start_i(timer_start_i),
        .unit_irq_i(unit_irq_i), .out_pin_o(out_pin_o), .switch_clk_o(switch_clk_o),
        .timer_on_prescaled_o(timer_on_prescaled_o), .low_carry_o(low_carry_o),
        .high_carry_o(high_carry_o));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic stop_test;
        $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1 d = rdata_o;
    endtask

    // The gap is counted between two low carry pulses, so divider phase does not matter.
    task automatic carry_gap(output int n);
        n = 0;
        do begin
            @(posedge clk_i);
            #1 n++;
        end while (low_carry_o !== 1'b1 && n < 6000);
        n = 0;
        do begin
            @(posedge clk_i);
            #1 n++;
        end while (low_carry_o !== 1'b1 && n < 6000);
        if (n >= 6000) begin
            error_cnt++;
            stop_test();
        end
    endtask

    // Runs stop-on-event for n cycles, freezes on the unit interrupt, reads and clears.
    task automatic run_stop(input logic [7:0] s, input logic [7:0] p, input int n,
                            output logic [7:0] lo, output logic [7:0] hi);
        logic [7:0] x;
        wr(AS, s);
        wr(AP, p);
        step(n);
        unit_irq_i <= 1'b1;
        step(20);
        rd(AL, lo);
        step(30);
        rd(AL, x);
        `CHK("held count", lo, x)
        rd(AH, hi);
        step(1);
        unit_irq_i <= 1'b0;
        wr(AP, p & 8'hfe);
        rd(AL, x);
        `CHK("cleared low", 8'h00, x)
        rd(AH, x);
        `CHK("cleared high", 8'h00, x)
    endtask

    initial begin
        error_cnt = 0;
        n_tests = 0;
        arst_n_i = 1'b0;
        {wr_i, rd_i, low_rate_osc_i, prs_i, timer_start_i, unit_irq_i} = 6'h00;
        addr_i = 8'h00;
        wdata_i = 8'h00;
        event_src_i = 7'h00;
        repeat (5) @(posedge clk_i);
        arst_n_i <= 1'b1;

        rd(AP, v);
        `CHK("primary reset", `CS_CTRL_PRIMARY_RESET, v)
        rd(AS, v);
        `CHK("secondary reset", `CS_CTRL_SECONDARY_RESET, v)
        wr(AS, 8'h5a);
        wr(8'h10, 8'hff);
        wr(AL, 8'h33);
        rd(AS, v);
        `CHK("secondary rw", 8'h5a, v)
        rd(8'h10, v);
        `CHK("unmapped", 8'h00, v)
        rd(AL, v);
        `CHK("count read only", 8'h00, v)
        $display("test registers done");

        for (k = 0; k < 4; k++) begin
            wr(AS, 8'(k << 5));
            wr(AP, 8'h87);
            carry_gap(t);
            `CHK("wrap period", 256 << k, t)
            @(posedge clk_i);
            #1 `CHK("out low carry", 1'b1, out_pin_o)
            wr(AP, 8'h86);
        end
        wr(AS, 8'h00);
        wr(AP, 8'hd7);
        carry_gap(t);
        `CHK("prescaled period", 256 * `CS_PRESCALE_DIV, t)
        `CHK("high carry", 1'b1, high_carry_o)
        @(posedge clk_i);
        #1 `CHK("out high carry", 1'b1, out_pin_o)
        wr(AP, 8'hd6);
        $display("test continuous done");

        run_stop(8'h00, 8'h01, 300, v, h);
        `CHK("independent high", v, h)
        run_stop(8'h80, 8'h01, 300, v, h);
        `CHK("chained high", 8'h01, h)
        fork
            run_stop(8'h10, 8'h01, 250, v, h);
            begin
                step(10);
                repeat (5) begin
                    low_rate_osc_i <= 1'b1;
                    step(10);
                    low_rate_osc_i <= 1'b0;
                    step(10);
                end
            end
        join
        `CHK("alt high clock", 8'h05, h)
        $display("test stop on event done");

        wr(AS, 8'h00);
        wr(AP, 8'h03);
        step(50);
        event_src_i <= 7'h01;
        step(100);
        event_src_i <= 7'h00;
        step(20);
        rd(AL, v);
        `CHK("pulse width", 1'b1, (v >= 8'd99 && v <= 8'd101))
        wr(AP, 8'h02);
        wr(AS, 8'h08);
        event_src_i <= 7'h01;
        step(5);
        wr(AP, 8'h05);
        step(50);
        event_src_i <= 7'h00;
        step(30);
        event_src_i <= 7'h01;
        step(50);
        event_src_i <= 7'h00;
        step(20);
        rd(AL, v);
        `CHK("inverted period", 1'b1, (v >= 8'd79 && v <= 8'd81))
        wr(AP, 8'h04);
        $display("test edge modes done");

        event_src_i <= 7'h01;
        run_stop(8'h00, 8'h09, 100, v, h);
        `CHK("gate closed", 8'h00, v)
        `CHK("timer clock", 1'b1, timer_on_prescaled_o)
        timer_start_i <= 1'b1;
        run_stop(8'h00, 8'h09, 100, v, h);
        `CHK("gate open", 1'b1, (v >= 8'd90 && v <= 8'd105))
        timer_start_i <= 1'b0;
        wr(AP, 8'h20);
        prs_i <= 1'b1;
        step(5);
        #1 `CHK("timer clock off", 1'b0, timer_on_prescaled_o)
        `CHK("switch prs high", 1'b1, switch_clk_o)
        step(1);
        prs_i <= 1'b0;
        step(5);
        #1 `CHK("switch prs low", 1'b0, switch_clk_o)
        wr(AP, 8'h00);
        t = 0;
        repeat (16) begin
            @(posedge clk_i);
            #1 if (switch_clk_o === 1'b1) t++;
        end
        `CHK("free prescaler", 4, t)
        $display("test sigma delta done");

        wr(AP, 8'h40);
        unit_irq_i <= 1'b1;
        step(2);
        #1 `CHK("out irq high", 1'b1, out_pin_o)
        step(1);
        unit_irq_i <= 1'b0;
        step(2);
        #1 `CHK("out irq low", 1'b0, out_pin_o)
        wr(AP, 8'h00);
        for (k = 0; k < 8; k++) begin
            wr(AS, 8'(k));
            event_src_i <= (k == 7) ? 7'h7f : 7'(1 << k);
            step(6);
            #1 `CHK("input select on", (k < 7), out_pin_o)
            step(1);
            event_src_i <= (k == 7) ? 7'h7f : ~7'(1 << k);
            step(6);
            #1 `CHK("input select off", 1'b0, out_pin_o)
        end
        wr(AS, 8'h0f);
        step(6);
        #1 `CHK("invert zero", 1'b1, out_pin_o)
        $display("test output select done");
        stop_test();
    end
endmodule
